// File: rtl/sgio_pkg.sv
// Package: constants, enums and carriers for the signalling I/O module
package sgio_pkg;

    // =====================================================================
    // Register map (word addresses, consecutive)
    // =====================================================================
    localparam logic [3:0] SGIO_ADDR_CTRL     = 4'h0; // Control and link
    localparam logic [3:0] SGIO_ADDR_FUNC     = 4'h1; // Output functions
    localparam logic [3:0] SGIO_ADDR_POL      = 4'h2; // Contact polarity
    localparam logic [3:0] SGIO_ADDR_SHED     = 4'h3; // Shed delay, ms
    localparam logic [3:0] SGIO_ADDR_PRE      = 4'h4; // Pre-signal delay, ms
    localparam logic [3:0] SGIO_ADDR_POST     = 4'h5; // Post-signal delay, ms
    localparam logic [3:0] SGIO_ADDR_STATUS   = 4'h6; // Read-only state
    localparam logic [3:0] SGIO_ADDR_ID       = 4'h7; // Instance index

    // =====================================================================
    // Control register field positions
    // =====================================================================
    localparam int SGIO_CTRL_COMM_BIT   = 0; // Main unit talking
    localparam int SGIO_CTRL_SRC1_BIT   = 1; // First source healthy
    localparam int SGIO_CTRL_SRC2_BIT   = 2; // Second source healthy
    localparam int SGIO_CTRL_XREQ_BIT   = 3; // Transfer request pulse
    localparam int SGIO_CTRL_XDONE_BIT  = 4; // Transfer done pulse
    localparam int SGIO_CTRL_ONPRI_BIT  = 5; // Load on priority source
    localparam int SGIO_CTRL_DISC_BIT   = 6; // Output mask kept on loss
    localparam int SGIO_CTRL_DISC_W     = 2;

    // =====================================================================
    // Reset values
    // =====================================================================
    localparam logic [31:0] SGIO_CTRL_RST = 32'h0000_0020;
    localparam logic [31:0] SGIO_FUNC_RST = 32'h0000_0000;
    localparam logic [31:0] SGIO_POL_RST  = 32'h0000_0000; // All NO
    localparam logic [31:0] SGIO_DLY_RST  = 32'h0000_0000;

    // =====================================================================
    // Timing
    // =====================================================================
    localparam int SGIO_CLK_MHZ       = 200;
    localparam int SGIO_MS_NS         = 1000000;
    localparam int SGIO_CLK_NS        = 1000 / SGIO_CLK_MHZ;
    localparam int SGIO_MS_CYC        = SGIO_MS_NS / SGIO_CLK_NS;
    localparam int SGIO_LOSS_MS       = 8000;   // Loss time before outputs drop
    localparam int SGIO_FLASH_MS      = 1000;   // Flash pattern period
    localparam int SGIO_FLASH_ON_MS   = 100;    // Each quick flash length
    localparam int SGIO_FLASH_GAP_MS  = 200;    // Second flash start

    // =====================================================================
    // Output function codes
    // =====================================================================
    typedef enum logic [2:0] {
        SGIO_FN_NONE  = 3'h0,
        SGIO_FN_SRC1  = 3'h1,
        SGIO_FN_SRC2  = 3'h2,
        SGIO_FN_SHED  = 3'h3,
        SGIO_FN_ELEV  = 3'h4
    } sgio_func_t;

    // Transfer sequencer states, one-hot
    typedef enum logic [3:0] {
        SGIO_ST_IDLE = 4'b0001,
        SGIO_ST_PRE  = 4'b0010,
        SGIO_ST_WAIT = 4'b0100,
        SGIO_ST_POST = 4'b1000
    } sgio_state_t;

    // Physical I/O carrier
    typedef struct packed {
        logic [1:0] relay;     // Relay coil drive per contact
        logic       led_power; // Power indicator
        logic [1:0] led_in;    // Input indicators
        logic [1:0] led_out;   // Contact indicators
        logic       xfer_go;   // Transfer may proceed
    } sgio_pins_t;

endpackage

// File: rtl/sgio_top.sv
// Signalling I/O module: two inputs, two relay outputs, indicators
//
// The Avalon-MM register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module sgio_top
    import sgio_pkg::*;
#(
    parameter logic [1:0] INSTANCE_IDX = 2'h1,
    parameter int         LOSS_CYC     = SGIO_LOSS_MS * SGIO_MS_CYC,
    parameter int         MS_CYC       = SGIO_MS_CYC
) (
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    input  wire logic        clk_en,
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output var  logic [31:0] avs_readdata,
    output var  logic        avs_waitrequest,
    input  wire logic        first_input_terminal,
    input  wire logic        second_input_terminal,
    input  wire logic [1:0]  contact_sense,
    output var  sgio_pins_t  pins
);

    // =====================================================================
    // Pin synchronisers
    // =====================================================================
    logic [3:0] sync1_q, sync2_q;     // Two stages for raw pins
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            sync1_q <= 4'h0;
            sync2_q <= 4'h0;
        end else if (clk_en) begin
            sync1_q <= {contact_sense, second_input_terminal,
                        first_input_terminal};
            sync2_q <= sync1_q;
        end
    end
    wire logic [1:0] in_raw   = sync2_q[1:0]; // High = shorted to common
    wire logic [1:0] ct_raw   = sync2_q[3:2]; // High = contact closed

    // =====================================================================
    // Register file
    // =====================================================================
    logic [31:0] ctrl_q, ctrl_d;     // Link and source state
    logic [31:0] func_q, func_d;     // 3 bits per output
    logic [31:0] pol_q, pol_d;       // [1:0] inputs, [3:2] outputs NC
    logic [31:0] shed_q, shed_d;     // Shed delay ms
    logic [31:0] pre_q, pre_d;       // Pre-signal delay ms
    logic [31:0] post_q, post_d;     // Post-signal delay ms
    logic [31:0] rdata_d;
    logic        wait_q, wait_d;     // One wait per access

    // Byte-lane merge
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // Status word, assembled below
    logic [31:0] status_w;

    // Access completes on the cycle waitrequest is low
    always_comb begin
        ctrl_d  = ctrl_q;
        func_d  = func_q;
        pol_d   = pol_q;
        shed_d  = shed_q;
        pre_d   = pre_q;
        post_d  = post_q;
        rdata_d = avs_readdata;
        wait_d  = 1'b1;
        // Pulses self-clear after one cycle
        ctrl_d[SGIO_CTRL_XREQ_BIT]  = 1'b0;
        ctrl_d[SGIO_CTRL_XDONE_BIT] = 1'b0;
        // Read data is registered while waitrequest is still high
        if ((avs_read || avs_write) && wait_q) begin
            wait_d = 1'b0;
            if (avs_read) begin
                case (avs_address)
                    SGIO_ADDR_CTRL:   rdata_d = ctrl_q;
                    SGIO_ADDR_FUNC:   rdata_d = func_q;
                    SGIO_ADDR_POL:    rdata_d = pol_q;
                    SGIO_ADDR_SHED:   rdata_d = shed_q;
                    SGIO_ADDR_PRE:    rdata_d = pre_q;
                    SGIO_ADDR_POST:   rdata_d = post_q;
                    SGIO_ADDR_STATUS: rdata_d = status_w;
                    SGIO_ADDR_ID:     rdata_d = {30'h0, INSTANCE_IDX};
                    default:          rdata_d = 32'h0;
                endcase
            end
        end
        // Write lands only at the edge that ends the cycle with waitrequest low
        if (avs_write && !wait_q) begin
            case (avs_address)
                SGIO_ADDR_CTRL: ctrl_d = merge(ctrl_q, avs_writedata,
                                               avs_byteenable);
                SGIO_ADDR_FUNC: func_d = merge(func_q, avs_writedata,
                                               avs_byteenable);
                SGIO_ADDR_POL:  pol_d  = merge(pol_q, avs_writedata,
                                               avs_byteenable);
                SGIO_ADDR_SHED: shed_d = merge(shed_q, avs_writedata,
                                               avs_byteenable);
                SGIO_ADDR_PRE:  pre_d  = merge(pre_q, avs_writedata,
                                               avs_byteenable);
                SGIO_ADDR_POST: post_d = merge(post_q, avs_writedata,
                                               avs_byteenable);
                default: ;      // Unmapped writes ignored
            endcase
        end
    end

    // Register update
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            ctrl_q       <= SGIO_CTRL_RST;
            func_q       <= SGIO_FUNC_RST;
            pol_q        <= SGIO_POL_RST;
            shed_q       <= SGIO_DLY_RST;
            pre_q        <= SGIO_DLY_RST;
            post_q       <= SGIO_DLY_RST;
            avs_readdata <= 32'h0;
            wait_q       <= 1'b1;
        end else if (clk_en) begin
            ctrl_q       <= ctrl_d;
            func_q       <= func_d;
            pol_q        <= pol_d;
            shed_q       <= shed_d;
            pre_q        <= pre_d;
            post_q       <= post_d;
            avs_readdata <= rdata_d;
            wait_q       <= wait_d;
        end
    end
    assign avs_waitrequest = wait_q;

    // =====================================================================
    // Millisecond tick, loss timer and flash timer
    // =====================================================================
    logic [31:0] ms_cnt_q, ms_cnt_d;     // Cycles within a millisecond
    logic [31:0] loss_q, loss_d;         // Cycles since link dropped
    logic [15:0] flash_q, flash_d;       // Ms within flash period
    logic        ms_tick;
    logic        comm;
    logic        lost_q, lost_d;         // Loss persisted long enough

    assign comm    = ctrl_q[SGIO_CTRL_COMM_BIT];
    assign ms_tick = (ms_cnt_q == 32'(MS_CYC - 1));

    // Free-running flash, not tied to main unit's lamp
    always_comb begin
        ms_cnt_d = ms_tick ? 32'h0 : ms_cnt_q + 32'h1;
        flash_d  = flash_q;
        if (ms_tick) begin
            flash_d = (flash_q == 16'(SGIO_FLASH_MS - 1)) ? 16'h0
                                                          : flash_q + 16'h1;
        end
        loss_d = loss_q;
        lost_d = lost_q;
        if (comm) begin
            loss_d = 32'h0;
            lost_d = 1'b0;
        end else if (loss_q >= 32'(LOSS_CYC - 1)) begin
            lost_d = 1'b1;
        end else begin
            loss_d = loss_q + 32'h1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            ms_cnt_q <= 32'h0;
            flash_q  <= 16'h0;
            loss_q   <= 32'h0;
            lost_q   <= 1'b0;
        end else if (clk_en) begin
            ms_cnt_q <= ms_cnt_d;
            flash_q  <= flash_d;
            loss_q   <= loss_d;
            lost_q   <= lost_d;
        end
    end

    // =====================================================================
    // Transfer sequencer: shed and elevator timing
    // =====================================================================
    sgio_state_t st_q, st_d;
    logic [31:0] dly_q, dly_d;       // Remaining ms in current phase
    logic        shed_q_on, shed_d_on; // Shed output latch
    logic        xreq, xdone, onpri;

    assign xreq  = ctrl_q[SGIO_CTRL_XREQ_BIT];
    assign xdone = ctrl_q[SGIO_CTRL_XDONE_BIT];
    assign onpri = ctrl_q[SGIO_CTRL_ONPRI_BIT];

    // Request holds off transfer for the longer lead delay
    always_comb begin
        st_d      = st_q;
        dly_d     = dly_q;
        shed_d_on = shed_q_on;
        if (ms_tick && dly_q != 32'h0) begin
            dly_d = dly_q - 32'h1;
        end
        case (st_q)
            SGIO_ST_IDLE: begin
                if (xreq) begin
                    st_d  = SGIO_ST_PRE;
                    dly_d = (shed_q > pre_q) ? shed_q : pre_q;
                    if (onpri) begin
                        shed_d_on = 1'b1;
                    end
                end
            end
            SGIO_ST_PRE: begin
                if (dly_q == 32'h0) begin
                    st_d = SGIO_ST_WAIT;
                end
            end
            SGIO_ST_WAIT: begin
                if (xdone) begin
                    st_d  = SGIO_ST_POST;
                    dly_d = post_q;
                end
            end
            SGIO_ST_POST: begin
                if (dly_q == 32'h0) begin
                    st_d = SGIO_ST_IDLE;
                end
            end
            default: st_d = SGIO_ST_IDLE;
        endcase
        // Shed drops once load is back on priority source
        if (onpri && st_q == SGIO_ST_IDLE && !xreq) begin
            shed_d_on = 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            st_q      <= SGIO_ST_IDLE;
            dly_q     <= 32'h0;
            shed_q_on <= 1'b0;
        end else if (clk_en) begin
            st_q      <= st_d;
            dly_q     <= dly_d;
            shed_q_on <= shed_d_on;
        end
    end

    // =====================================================================
    // Output functions, polarity and indicators
    // =====================================================================
    logic [1:0] act;          // Logical activity per output
    logic [1:0] relay_d;
    logic       elev_on;
    logic       pwr_d;
    logic [1:0] in_act;

    assign elev_on = (st_q != SGIO_ST_IDLE);
    // Gate opens in WAIT, after the longer of shed and pre delays, whether or not shed is in use
    wire logic go_d = (st_q == SGIO_ST_WAIT);

    always_comb begin
        for (int i = 0; i < 2; i++) begin
            case (sgio_func_t'(func_q[i*3 +: 3]))
                SGIO_FN_SRC1: act[i] = ctrl_q[SGIO_CTRL_SRC1_BIT];
                SGIO_FN_SRC2: act[i] = ctrl_q[SGIO_CTRL_SRC2_BIT];
                SGIO_FN_SHED: act[i] = shed_q_on;
                SGIO_FN_ELEV: act[i] = elev_on;
                default:      act[i] = 1'b0;
            endcase
            // Long loss drops outputs except those kept on loss
            if (lost_q && !ctrl_q[SGIO_CTRL_DISC_BIT + i]) begin
                act[i] = 1'b0;
            end
            // NC polarity: active means contact open
            relay_d[i] = act[i] ^ pol_q[2 + i];
            in_act[i]  = in_raw[i] ^ pol_q[i];
        end
        // Steady with link, double flash without, at once
        if (comm) begin
            pwr_d = 1'b1;
        end else begin
            pwr_d = (flash_q < 16'(SGIO_FLASH_ON_MS)) ||
                    (flash_q >= 16'(SGIO_FLASH_GAP_MS) &&
                     flash_q < 16'(SGIO_FLASH_GAP_MS + SGIO_FLASH_ON_MS));
        end
    end

    // Status: [1:0] input On, [3:2] contact Closed, [4] lost, [5] link
    assign status_w = {26'h0, comm, lost_q, ct_raw, in_act};

    // Pins registered; input and contact lamps use raw synchronised state
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            pins <= '0;
        end else if (clk_en) begin
            pins.relay     <= relay_d;
            pins.led_power <= pwr_d;
            pins.led_in    <= in_raw;
            pins.led_out   <= ct_raw;
            pins.xfer_go   <= go_d;
        end
    end

endmodule

`default_nettype wire

// File: sim/sgio_relay_model.sv
// Relay model: contacts follow the coil drive after armature travel
`timescale 1ns/1ps
`default_nettype none
module sgio_relay_model (
    input  wire logic       clk_sys,
    input  wire logic [1:0] relay,
    output wire logic [1:0] contact_sense
);
    // ========
    // Travel pipeline, three cycles, so sense never tracks the coil at once
    logic [5:0] travel_q = 6'h00; // Armature positions in flight
    always @(posedge clk_sys) begin
        travel_q <= {travel_q[3:0], relay};
    end
    assign contact_sense = travel_q[5:4]; // Closed contact reads high
endmodule
`default_nettype wire

// File: sim/sgio_chk.sv
// Checker: port-level assertions for the signalling I/O block
`timescale 1ns/1ps
`default_nettype none
module sgio_chk
    import sgio_pkg::*;
#(
    parameter logic [1:0] INSTANCE_IDX = 2'h1
) (
    input wire logic        clk_sys,
    input wire logic        reset_n,
    input wire logic        clk_en,
    input wire logic [3:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0]  avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        first_input_terminal,
    input wire logic        second_input_terminal,
    input wire logic [1:0]  contact_sense,
    input wire sgio_pins_t  pins
);
    // ========
    // Helper state: cycles since reset and shadow of input polarity
    logic [2:0] up_q;  // Saturating count; pipes are full at 3
    logic [2:0] up_d;
    logic [1:0] pol_q; // Input polarity as last written
    logic [1:0] pol_d;
    always_comb begin
        up_d = (up_q == 3'h7) ? up_q : up_q + 3'h1;
        pol_d = pol_q;
        // Write lands only at the edge that ends the cycle with waitrequest low
        if (avs_write && !avs_waitrequest && avs_byteenable[0]
            && avs_address == SGIO_ADDR_POL) begin
            pol_d = avs_writedata[1:0];
        end
    end
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            up_q <= 3'h0;
            pol_q <= 2'h0;
        end else begin
            up_q <= up_d;
            pol_q <= pol_d;
        end
    end
    // ========
    // Assertions
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    bus_answer_a: assert property (
        (avs_read || avs_write) && avs_waitrequest && clk_en
        |=> !avs_waitrequest) else $error("bus request not answered");
    wait_pulse_a: assert property (
        !avs_waitrequest |=> avs_waitrequest) else $error("ack too long");
    in1_lamp_a: assert property (
        up_q > 3'h2 |-> pins.led_in[0] == $past(first_input_terminal, 3))
        else $error("first input lamp wrong");
    in2_lamp_a: assert property (
        up_q > 3'h2 |-> pins.led_in[1] == $past(second_input_terminal, 3))
        else $error("second input lamp wrong");
    out_lamp_a: assert property (
        up_q > 3'h2 |-> pins.led_out == $past(contact_sense, 3))
        else $error("contact lamp wrong");
    inst_index_a: assert property (
        avs_read && avs_waitrequest && avs_address == SGIO_ADDR_ID
        |=> avs_readdata == {30'h0, INSTANCE_IDX}) else $error("bad index");
    input_state_a: assert property (
        avs_read && !avs_waitrequest && avs_address == SGIO_ADDR_STATUS
        && up_q > 3'h2 |-> avs_readdata[1:0] == (pins.led_in ^ pol_q))
        else $error("input state report wrong");
    contact_state_a: assert property (
        avs_read && !avs_waitrequest && avs_address == SGIO_ADDR_STATUS
        && up_q > 3'h2 |-> avs_readdata[3:2] == pins.led_out)
        else $error("contact state report wrong");
endmodule
bind sgio_top sgio_chk #(.INSTANCE_IDX(INSTANCE_IDX)) u_sgio_chk (
    .clk_sys(clk_sys), .reset_n(reset_n), .clk_en(clk_en),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .first_input_terminal(first_input_terminal),
    .second_input_terminal(second_input_terminal),
    .contact_sense(contact_sense), .pins(pins));
`default_nettype wire

// File: sim/tb.sv
// Testbench: bus sequences checking the signalling I/O block
`timescale 1ns/1ps
`default_nettype none
module tb;
    import sgio_pkg::*;
    // ========
    // Signals
    logic        clk_sys = 1'b0;      // 200 MHz
    logic        reset_n = 1'b0;      // Held low 12 cycles
    logic [3:0]  avs_address = 4'h0;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0]  avs_byteenable = 4'hF; // Lanes, narrowed once
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        in_a = 1'b0;         // First input, high = shorted
    logic        in_b = 1'b0;         // Second input
    logic [1:0]  contact_sense;       // From the relay model
    sgio_pins_t  pins;
    int          mismatches = 0;
    int          cmp_count = 0;
    int          cyc = 0;             // Timeout counter
    int          lit;                 // Lit cycles of power lamp
    int          rises;               // Flashes seen
    logic        prev;
    logic [31:0] q;
    always #2.5 clk_sys = ~clk_sys;
    // Short counts keep the run small: 50 cycles loss, 4 cycles per ms
    sgio_top #(.INSTANCE_IDX(2'h2), .LOSS_CYC(50), .MS_CYC(4)) u_sgio_top (
        .clk_sys(clk_sys), .reset_n(reset_n), .clk_en(1'b1),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .first_input_terminal(in_a),
        .second_input_terminal(in_b), .contact_sense(contact_sense),
        .pins(pins));
    sgio_relay_model u_sgio_relay_model (
        .clk_sys(clk_sys), .relay(pins.relay),
        .contact_sense(contact_sense));
    // ========
    // Tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Request held until waitrequest is sampled low, then released
    task automatic bus(input logic wr, input logic [3:0] a,
                       input logic [31:0] d);
        @(posedge clk_sys);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(q, exp);
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic results();
        $display("Comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Hang guard, well above the expected run
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            results();
        end
    end
    // ========
    // Main sequence
    initial begin
        wt(12);
        reset_n <= 1'b1;
        // Reset values, unmapped and read-only places
        rd(SGIO_ADDR_CTRL, SGIO_CTRL_RST);
        rd(SGIO_ADDR_FUNC, SGIO_FUNC_RST);
        rd(SGIO_ADDR_POL, SGIO_POL_RST);
        rd(SGIO_ADDR_SHED, SGIO_DLY_RST);
        // Only the low lane of a narrowed write may land
        avs_byteenable <= 4'h1;
        wr(SGIO_ADDR_SHED, 32'hFFFF_FF05);
        avs_byteenable <= 4'hF;
        rd(SGIO_ADDR_SHED, 32'h5);
        rd(4'h8, 32'h0);
        wr(SGIO_ADDR_ID, 32'h0);
        rd(SGIO_ADDR_ID, 32'h2);
        chk(32'(pins.relay), 32'h0);
        // Source-available outputs, contact report and lamps
        wr(SGIO_ADDR_FUNC, 32'h11);
        wr(SGIO_ADDR_CTRL, 32'h23);
        wt(12);
        chk(32'(pins.relay), 32'h1);
        chk(32'(pins.led_out), 32'h1);
        chk(32'(pins.led_power), 32'h1);
        rd(SGIO_ADDR_STATUS, 32'h24);
        in_a <= 1'b1;
        wt(6);
        chk(32'(pins.led_in), 32'h1);
        rd(SGIO_ADDR_STATUS, 32'h25);
        // Normally-closed first input and both outputs; lamps stay physical
        in_b <= 1'b1;
        wr(SGIO_ADDR_POL, 32'hD);
        wt(12);
        chk(32'(pins.relay), 32'h2);
        chk(32'(pins.led_in), 32'h3);
        rd(SGIO_ADDR_STATUS, 32'h2A);
        wr(SGIO_ADDR_POL, 32'h0);
        wr(SGIO_ADDR_CTRL, 32'h27);
        wt(12);
        chk(32'(pins.relay), 32'h3);
        // Loss of link; second output kept on disconnection
        wr(SGIO_ADDR_CTRL, 32'hA6);
        wt(20);
        chk(32'(pins.relay), 32'h3);
        wt(60);
        chk(32'(pins.relay), 32'h2);
        rd(SGIO_ADDR_STATUS, 32'h1B);
        lit = 0;
        rises = 0;
        prev = pins.led_power;
        repeat (4000) begin
            @(posedge clk_sys);
            lit += int'(pins.led_power === 1'b1);
            rises += int'(pins.led_power === 1'b1 && prev === 1'b0);
            prev = pins.led_power;
        end
        chk(lit, 32'h320);
        chk(rises, 32'h2);
        wr(SGIO_ADDR_CTRL, 32'h21);
        wt(2);
        chk(32'(pins.led_power), 32'h1);
        // Shed and elevator around one transfer
        wr(SGIO_ADDR_FUNC, 32'h23);
        wr(SGIO_ADDR_SHED, 32'h2);
        wr(SGIO_ADDR_PRE, 32'h3);
        wr(SGIO_ADDR_POST, 32'h2);
        wr(SGIO_ADDR_CTRL, 32'h29);
        wt(4);
        chk(32'(pins.relay), 32'h3);
        chk(32'(pins.xfer_go), 32'h0);
        wt(16);
        chk(32'(pins.xfer_go), 32'h1);
        wr(SGIO_ADDR_CTRL, 32'h11);
        wt(4);
        chk(32'(pins.relay), 32'h3);
        wt(12);
        chk(32'(pins.relay), 32'h1);
        wr(SGIO_ADDR_CTRL, 32'h21);
        wt(4);
        chk(32'(pins.relay), 32'h0);
        results();
    end
endmodule
`default_nettype wire
